// file: hdl/t8cc_pkg.sv
// What this block does
// - count 0x00 is the bottom indication
// - count 0xFF is the maximum indication
// - top is 0xFF or compare A, per mode
// - counter and compare registers are 8 bits
// - each request has a flag and mask bit
// - clock select picks prescaler or pin edge
// - clock select zero stops the counter
// - each tick clears, increments or decrements count
// - cpu reads and writes count at any time
// - cpu count write beats clear or step
// - three-bit wave mode split over two controls
// - overflow flag set at mode-dependent points
// - two comparators match count against compares
// - match sets its flag on next tick
// - masked flag requests; ack or one clears
// - wave output from matches, mode and extremes
// - compare double buffered only in pwm modes
// - buffer copies to compare at top in both pwm modes
// - cpu reaches buffer or working compare directly
// - force strobe acts like match in non-pwm
// - force sets no flag, leaves counter alone
// - clock select one ticks every system clock
// - select 7 rising, 6 falling pin edges
// - count write blocks matches on next tick
package t8cc_pkg;

   // register byte addresses on the bus
   localparam logic [31:0] OFS_CTRL_A  = 32'h0000_0000;
   localparam logic [31:0] OFS_CTRL_B  = 32'h0000_0004;
   localparam logic [31:0] OFS_COUNT   = 32'h0000_0008;
   localparam logic [31:0] OFS_CMP_A   = 32'h0000_000c;
   localparam logic [31:0] OFS_CMP_B   = 32'h0000_0010;
   localparam logic [31:0] OFS_MASK    = 32'h0000_0014;
   localparam logic [31:0] OFS_FLAG    = 32'h0000_0018;
   localparam logic [31:0] OFS_POWER   = 32'h0000_001c;

   // field positions
   localparam int CA_COMA_LSB = 6;
   localparam int CA_COMB_LSB = 4;
   localparam int CA_WM_LSB   = 0;
   localparam int CB_FOCA_BIT = 7;
   localparam int CB_FOCB_BIT = 6;
   localparam int CB_WM2_BIT  = 3;
   localparam int CB_CS_LSB   = 0;
   localparam int FL_OVF      = 0;
   localparam int FL_MA       = 1;
   localparam int FL_MB       = 2;
   localparam int PW_BIT      = 0;

   // reset values
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [2:0] RST_BITS3 = 3'h0;
   localparam logic       RST_POWER = 1'b0;

   // counter extremes
   localparam logic [7:0] BOTTOM_VAL = 8'h00;
   localparam logic [7:0] MAX_VAL    = 8'hff;
   localparam logic [7:0] ONE_VAL    = 8'h01;

   // clock select codes
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIRECT   = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // prescaler taps: tick when the masked bits are all ones
   localparam int         PRE_W     = 10;
   localparam logic [9:0] TAP_8     = 10'h007;
   localparam logic [9:0] TAP_64    = 10'h03f;
   localparam logic [9:0] TAP_256   = 10'h0ff;
   localparam logic [9:0] TAP_1024  = 10'h3ff;
   localparam logic [9:0] PRE_ONE   = 10'h001;
   localparam logic [9:0] PRE_ZERO  = 10'h000;

   // wave modes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_CTC    = 3'h2;
   localparam logic [1:0] WM_PHASE  = 2'h1;
   localparam logic [1:0] WM_FAST   = 2'h3;

   // compare output mode actions
   localparam logic [1:0] COM_NONE   = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_RDWAIT,
      BUS_READ
   } t8cc_bus_t;

   typedef struct packed {
      logic       enable;
      logic [2:0] sel;
   } t8cc_clk_cfg_t;

   typedef struct packed {
      logic [9:0] pre;
      logic       pin_now;
      logic       pin_prev;
   } t8cc_pre_state_t;

   typedef struct packed {
      logic [1:0]  wm_lo;
      logic [1:0]  com_a;
      logic [1:0]  com_b;
      logic        wm_hi;
      logic [2:0]  cs;
      logic [7:0]  count;
      logic [7:0]  cmp_a;
      logic [7:0]  cmp_b;
      logic [7:0]  buf_a;
      logic [7:0]  buf_b;
      logic [2:0]  mask;
      logic [2:0]  flag;
      logic        power_off;
      logic        down;
      logic        block;
      logic        out_a;
      logic        out_b;
      t8cc_bus_t   bus;
      logic [31:0] addr;
      logic [31:0] rdata;
   } t8cc_state_t;

endpackage : t8cc_pkg

// file: hdl/t8cc_clksel.sv
`timescale 1ns/100ps
module t8cc_clksel
   import t8cc_pkg::*;
(
   // clock and reset
   input  wire logic          REF_CLK,
   input  wire logic          RESETN,
   // selection and pin
   input  wire t8cc_clk_cfg_t cfg,
   input  wire logic          ext_pin,
   // timer tick
   output logic               tick
);

   t8cc_pre_state_t st;
   t8cc_pre_state_t next_st;
   logic            rise;
   logic            fall;

   // prescaler runs free, so the first prescaled tick lands anywhere
   // within one divisor period after the select changes
   always_comb
   begin
      next_st          = st;
      next_st.pre      = st.pre + PRE_ONE;
      next_st.pin_now  = ext_pin;
      next_st.pin_prev = st.pin_now;
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st <= '{pre: PRE_ZERO, pin_now: 1'b0, pin_prev: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rise = st.pin_now & ~st.pin_prev;
   assign fall = ~st.pin_now & st.pin_prev;

   always_comb
   begin
      tick = 1'b0;
      if (cfg.enable)
      begin
         unique case (cfg.sel)
            CS_STOP:     tick = 1'b0;
            CS_DIRECT:   tick = 1'b1;
            CS_DIV8:     tick = (st.pre & TAP_8) == TAP_8;
            CS_DIV64:    tick = (st.pre & TAP_64) == TAP_64;
            CS_DIV256:   tick = (st.pre & TAP_256) == TAP_256;
            CS_DIV1024:  tick = (st.pre & TAP_1024) == TAP_1024;
            CS_EXT_FALL: tick = fall;
            CS_EXT_RISE: tick = rise;
         endcase
      end
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);

   pin_rise_a: assert property (
      (cfg.enable && cfg.sel == CS_EXT_RISE && !ext_pin ##1 ext_pin)
      |=> (tick || !cfg.enable || cfg.sel != CS_EXT_RISE))
      else $error("rising pin edge gave no tick");

   div8_tap_a: assert property (
      (cfg.enable && cfg.sel == CS_DIV8 && tick) |=> !tick)
      else $error("divide by eight ticked twice in a row");

endmodule : t8cc_clksel

// file: hdl/t8cc_top.sv
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module t8cc_top
   import t8cc_pkg::*;
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RESETN,
   // ahb-lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // external count pin
   input  wire logic        EXT_COUNT_PIN,
   // interrupt requests and their service acknowledges
   output logic [2:0]       IRQ,
   input  wire logic [2:0]  IRQ_ACK,
   // compare outputs
   output logic             COMPARE_OUT_A,
   output logic             COMPARE_OUT_B
);

   t8cc_state_t   st;
   t8cc_state_t   next_st;
   t8cc_clk_cfg_t cfg;
   logic          tick;
   logic [2:0]    wm;
   logic          pwm;
   logic          fast;
   logic          phase;
   logic [7:0]    top;
   logic          at_top;
   logic          at_bottom;
   logic          at_max;
   logic          match_a;
   logic          match_b;
   logic          wr;
   logic          cnt_wr;
   logic          force_a;
   logic          force_b;
   logic [2:0]    set_fl;
   logic [2:0]    clr_fl;
   logic          bot_evt;
   logic          addr_ok;

   assign cfg = '{enable: ~st.power_off,
                  sel:    st.cs};

   t8cc_clksel u_clksel (
      .REF_CLK (REF_CLK),
      .RESETN  (RESETN),
      .cfg     (cfg),
      .ext_pin (EXT_COUNT_PIN),
      .tick    (tick)
   );

   // mode decode; odd mode codes are the pwm ones
   assign wm        = {st.wm_hi, st.wm_lo};
   assign pwm       = wm[0];
   assign fast      = wm[1:0] == WM_FAST;
   assign phase     = wm[1:0] == WM_PHASE;
   assign top       = (wm[2] || wm == WM_CTC) ? st.cmp_a : MAX_VAL;
   assign at_top    = st.count == top;
   assign at_bottom = st.count == BOTTOM_VAL;
   assign at_max    = st.count == MAX_VAL;
   assign match_a   = tick && st.count == st.cmp_a && !st.block;
   assign match_b   = tick && st.count == st.cmp_b && !st.block;
   assign bot_evt   = tick && fast && at_top;

   assign wr      = st.bus == BUS_WRITE;
   assign cnt_wr  = wr && st.addr == OFS_COUNT;
   assign force_a = wr && st.addr == OFS_CTRL_B && HWDATA[CB_FOCA_BIT];
   assign force_b = wr && st.addr == OFS_CTRL_B && HWDATA[CB_FOCB_BIT];
   assign addr_ok = HSEL && HTRANS[1] && HREADY;

   // next level of one compare output
   function automatic logic wave_next(
      input logic       out,
      input logic [1:0] com,
      input logic       match,
      input logic       frc,
      input logic       is_pwm,
      input logic       is_fast,
      input logic       up,
      input logic       bottom
   );
      logic r;
      r = out;
      if (!is_pwm)
      begin
         if (match || frc)
         begin
            unique case (com)
               COM_NONE:   r = out;
               COM_TOGGLE: r = ~out;
               COM_CLEAR:  r = 1'b0;
               COM_SET:    r = 1'b1;
            endcase
         end
      end
      else if (is_fast)
      begin
         // bottom wins so a compare equal to top gives a steady level
         if (bottom && com[1])
            r = ~com[0];
         else if (match && com[1])
            r = com[0];
      end
      else if (match && com[1])
      begin
         r = up ? com[0] : ~com[0];
      end
      return r;
   endfunction : wave_next

   always_comb
   begin
      next_st = st;
      set_fl  = 3'h0;
      clr_fl  = IRQ_ACK;

      if (tick)
      begin
         next_st.block = 1'b0;
         if (phase)
         begin
            if (!st.down)
            begin
               if (at_top)
               begin
                  next_st.down  = 1'b1;
                  next_st.count = st.count - ONE_VAL;
               end
               else
               begin
                  next_st.count = st.count + ONE_VAL;
               end
            end
            else if (at_bottom)
            begin
               next_st.down  = 1'b0;
               next_st.count = st.count + ONE_VAL;
            end
            else
            begin
               next_st.count = st.count - ONE_VAL;
            end
         end
         else if (wm == WM_CTC || fast)
         begin
            next_st.count = at_top ? BOTTOM_VAL : st.count + ONE_VAL;
         end
         else
         begin
            next_st.count = st.count + ONE_VAL;
         end

         set_fl[FL_OVF] = phase ? (st.down && at_bottom)
                                : (fast ? at_top : at_max);
         set_fl[FL_MA]  = match_a;
         set_fl[FL_MB]  = match_b;

         // buffered compares update at top so a period never splits
         if ((fast && at_top) || (phase && at_top && !st.down))
         begin
            next_st.cmp_a = st.buf_a;
            next_st.cmp_b = st.buf_b;
         end
      end

      next_st.out_a = wave_next(st.out_a, st.com_a, match_a, force_a,
                                pwm, fast, !st.down, bot_evt);
      next_st.out_b = wave_next(st.out_b, st.com_b, match_b, force_b,
                                pwm, fast, !st.down, bot_evt);

      if (wr)
      begin
         unique case (st.addr)
            OFS_CTRL_A:
            begin
               next_st.wm_lo = HWDATA[CA_WM_LSB +: 2];
               next_st.com_a = HWDATA[CA_COMA_LSB +: 2];
               next_st.com_b = HWDATA[CA_COMB_LSB +: 2];
            end
            OFS_CTRL_B:
            begin
               next_st.wm_hi = HWDATA[CB_WM2_BIT];
               next_st.cs    = HWDATA[CB_CS_LSB +: 3];
            end
            OFS_COUNT:
            begin
               next_st.count = HWDATA[7:0];
               next_st.block = 1'b1;
            end
            OFS_CMP_A:
            begin
               next_st.buf_a = HWDATA[7:0];
               if (!pwm)
                  next_st.cmp_a = HWDATA[7:0];
            end
            OFS_CMP_B:
            begin
               next_st.buf_b = HWDATA[7:0];
               if (!pwm)
                  next_st.cmp_b = HWDATA[7:0];
            end
            OFS_MASK:  next_st.mask = HWDATA[2:0];
            OFS_FLAG:  clr_fl = clr_fl | HWDATA[2:0];
            OFS_POWER: next_st.power_off = HWDATA[PW_BIT];
            default:   next_st.mask = st.mask;
         endcase
      end

      // a hardware set in the clearing cycle survives
      next_st.flag = (st.flag & ~clr_fl) | set_fl;

      unique case (st.bus)
         BUS_IDLE, BUS_WRITE, BUS_READ:
         begin
            next_st.bus = BUS_IDLE;
            if (addr_ok)
            begin
               next_st.addr = HADDR;
               next_st.bus  = HWRITE ? BUS_WRITE : BUS_RDWAIT;
            end
         end
         BUS_RDWAIT:
         begin
            // one wait state so a write just before is seen
            next_st.bus   = BUS_READ;
            next_st.rdata = 32'h0000_0000;
            unique case (st.addr)
               OFS_CTRL_A: next_st.rdata[7:0] =
                  {st.com_a, st.com_b, 2'h0, st.wm_lo};
               OFS_CTRL_B: next_st.rdata[7:0] =
                  {4'h0, st.wm_hi, st.cs};
               OFS_COUNT:  next_st.rdata[7:0] = st.count;
               OFS_CMP_A:  next_st.rdata[7:0] = st.buf_a;
               OFS_CMP_B:  next_st.rdata[7:0] = st.buf_b;
               OFS_MASK:   next_st.rdata[2:0] = st.mask;
               OFS_FLAG:   next_st.rdata[2:0] = st.flag;
               OFS_POWER:  next_st.rdata[0]   = st.power_off;
               default:    next_st.rdata      = 32'h0000_0000;
            endcase
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st <= '{wm_lo: 2'h0, com_a: 2'h0, com_b: 2'h0, wm_hi: 1'b0,
                 cs: RST_BITS3, count: RST_BYTE, cmp_a: RST_BYTE,
                 cmp_b: RST_BYTE, buf_a: RST_BYTE, buf_b: RST_BYTE,
                 mask: RST_BITS3, flag: RST_BITS3,
                 power_off: RST_POWER, down: 1'b0, block: 1'b0,
                 out_a: 1'b0, out_b: 1'b0, bus: BUS_IDLE,
                 addr: 32'h0000_0000, rdata: 32'h0000_0000};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign HRDATA        = st.rdata;
   assign HREADYOUT     = st.bus != BUS_RDWAIT;
   assign HRESP         = 1'b0;
   assign IRQ           = st.flag & st.mask;
   assign COMPARE_OUT_A = st.out_a;
   assign COMPARE_OUT_B = st.out_b;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);

   stop_hold_a: assert property (
      (st.cs == CS_STOP && !cnt_wr) |=> $stable(st.count))
      else $error("counter moved while stopped");

   write_wins_a: assert property (
      cnt_wr |=> st.count == $past(HWDATA[7:0]) && st.block)
      else $error("count write lost to a step");

   ovf_wrap_a: assert property (
      (tick && wm == WM_NORMAL && at_max && !cnt_wr)
      |=> at_bottom && st.flag[FL_OVF])
      else $error("normal wrap did not set overflow");

   match_next_a: assert property (
      (tick && st.count == st.cmp_a && !st.block)
      |=> st.flag[FL_MA])
      else $error("match did not set flag a");

   block_match_a: assert property (
      (st.block && tick && !st.flag[FL_MB]) |=> !st.flag[FL_MB])
      else $error("blocked match set flag b");

   ctc_clear_a: assert property (
      (tick && wm == WM_CTC && st.count == st.cmp_a && !cnt_wr)
      |=> st.count == BOTTOM_VAL)
      else $error("clear on match mode did not clear");

   ack_clear_a: assert property (
      (IRQ_ACK[FL_MA] && !set_fl[FL_MA]) |=> !st.flag[FL_MA])
      else $error("acknowledge did not clear flag a");

   mask_gate_a: assert property (
      ($rose(st.flag[FL_OVF]) && st.mask[FL_OVF]) |-> IRQ[FL_OVF])
      else $error("enabled overflow raised no request");

   force_tog_a: assert property (
      (force_a && !pwm && st.com_a == COM_TOGGLE && !match_a)
      |=> st.out_a != $past(st.out_a))
      else $error("force did not toggle output a");

   force_flag_a: assert property (
      (force_a && !match_a && !st.flag[FL_MA]) |=> !st.flag[FL_MA])
      else $error("force set flag a");

   buf_hold_a: assert property (
      (wr && st.addr == OFS_CMP_A && pwm && !tick)
      |=> $stable(st.cmp_a) && st.buf_a == $past(HWDATA[7:0]))
      else $error("pwm compare write bypassed buffer");

   direct_tick_a: assert property (
      (st.cs == CS_DIRECT && !st.power_off) |-> tick)
      else $error("direct select gave no tick");

   ovf_cover_c:   cover property (set_fl[FL_OVF]);
   match_cover_c: cover property (match_a && st.mask[FL_MA]);
   force_cover_c: cover property (force_b && !pwm);
   turn_cover_c:  cover property (phase && tick && at_top && !st.down);

endmodule : t8cc_top

// file: test/t8cc_host_model.sv
`timescale 1ns/100ps
module t8cc_host_model
   import t8cc_pkg::*;
(
   // clock
   input  wire logic        REF_CLK,
   // ahb-lite master
   output logic             HSEL,
   output logic [31:0]      HADDR,
   output logic [1:0]       HTRANS,
   output logic             HWRITE,
   output logic [2:0]       HSIZE,
   output logic [31:0]      HWDATA,
   input  wire logic        HREADY,
   input  wire logic [31:0] HRDATA,
   // a wait ran past its bound
   output logic             stuck
);
   initial
   begin
      {HSEL, HADDR, HTRANS, HWRITE, HWDATA, stuck} = '0;
      HSIZE = 3'h2;
   end

   // slave answer time is not assumed, only bounded
   task automatic rdy();
      int n;
      n = 0;
      @(posedge REF_CLK);
      while (HREADY !== 1'b1 && n < 20)
      begin
         @(posedge REF_CLK);
         n++;
      end
      if (n >= 20)
         stuck = 1'b1;
   endtask : rdy

   task automatic xfer(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
      @(posedge REF_CLK);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= w;
      rdy();
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      rdy();
      q = HRDATA;
   endtask : xfer

   task automatic enable_timer();
      logic [31:0] x;
      xfer(1'b1, OFS_POWER, 32'h0, x);
   endtask : enable_timer
endmodule : t8cc_host_model

// file: test/tb.sv
`timescale 1ns/100ps
module tb;
   import t8cc_pkg::*;
   logic        REF_CLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, stuck;
   logic [31:0] HADDR, HWDATA, HRDATA, q, c0;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE, IRQ, IRQ_ACK;
   logic        EXT_COUNT_PIN, COMPARE_OUT_A, COMPARE_OUT_B, hit, ea;
   logic [1:0]  c;
   int          mismatches, check_count, n;
   int          divs [5] = '{1, 8, 64, 256, 1024};

   initial REF_CLK = 1'b0;
   always #50 REF_CLK = ~REF_CLK;

   // a bus wait that ran out ends the run at once
   always @(posedge REF_CLK)
   begin
      if (stuck === 1'b1)
         end_of_test();
   end

   t8cc_host_model u_host (.REF_CLK(REF_CLK), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .stuck(stuck));

   t8cc_top u_dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_COUNT_PIN(EXT_COUNT_PIN),
      .IRQ(IRQ), .IRQ_ACK(IRQ_ACK), .COMPARE_OUT_A(COMPARE_OUT_A),
      .COMPARE_OUT_B(COMPARE_OUT_B));

   task automatic chk(input string nm, input logic [31:0] s, e);
      check_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] x;
      u_host.xfer(1'b1, a, d, x);
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      u_host.xfer(1'b0, a, 32'h0, r);
   endtask : rd

   task automatic cyc(input int k);
      repeat (k) @(posedge REF_CLK);
   endtask : cyc

   task automatic wait_irq(input int b, input int lim, output logic h);
      h = 1'b0;
      for (int i = 0; i < lim && !h; i++)
      begin
         @(posedge REF_CLK);
         h = (IRQ[b] === 1'b1);
      end
   endtask : wait_irq

   task automatic pulse();
      EXT_COUNT_PIN <= 1'b1;
      cyc(3);
      EXT_COUNT_PIN <= 1'b0;
      cyc(3);
   endtask : pulse

   function automatic logic frc_out(input logic o, input logic [1:0] m);
      case (m)
         COM_TOGGLE: return ~o;
         COM_CLEAR:  return 1'b0;
         COM_SET:    return 1'b1;
         default:    return o;
      endcase
   endfunction : frc_out

   task automatic end_of_test();
      if (stuck !== 1'b0)
         mismatches++;
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      RESETN = 1'b0;
      EXT_COUNT_PIN = 1'b0;
      IRQ_ACK = 3'h0;
      void'($urandom(27));
      cyc(20);
      RESETN <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         rd(i * 4, q);
         chk("reset value", q, 32'h0);
      end
      chk("reset outs", {IRQ, COMPARE_OUT_A, COMPARE_OUT_B, HRESP}, 6'h0);
      wr(32'h20, 32'hff);
      rd(32'h20, q);
      chk("unmapped", q, 32'h0);
      u_host.enable_timer();
      wr(OFS_COUNT, 32'hffff_ffa5);
      cyc(20);
      rd(OFS_COUNT, q);
      chk("stopped count", q, 32'ha5);
      wr(OFS_POWER, 32'h1);
      wr(OFS_CTRL_B, CS_DIRECT);
      cyc(20);
      rd(OFS_COUNT, q);
      chk("power gated", q, 32'ha5);
      u_host.enable_timer();
      for (int s = 1; s < 6; s++)
      begin
         wr(OFS_CTRL_B, 32'h0);
         wr(OFS_COUNT, 32'h0);
         wr(OFS_CTRL_B, s);
         cyc(4 * divs[s-1]);
         wr(OFS_CTRL_B, 32'h0);
         rd(OFS_COUNT, q);
         chk("tick rate", q >= 3 && q <= 5 + 8 / divs[s-1], 1);
      end
      wr(OFS_MASK, 32'h1);
      wr(OFS_COUNT, 32'hf8);
      wr(OFS_CTRL_B, CS_DIRECT);
      wait_irq(FL_OVF, 30, hit);
      chk("overflow irq", hit, 1);
      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_FLAG, 32'h7);
      rd(OFS_FLAG, q);
      chk("flag clear", q, 32'h0);
      chk("irq low", IRQ, 3'h0);
      wr(OFS_CTRL_A, WM_CTC);
      wr(OFS_CMP_A, 32'h10);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_MASK, 32'h2);
      wr(OFS_CTRL_B, CS_DIRECT);
      wait_irq(FL_MA, 40, hit);
      chk("match irq", hit, 1);
      repeat (8)
      begin
         rd(OFS_COUNT, q);
         chk("ctc top", q <= 32'h10, 1);
      end
      wr(OFS_CTRL_B, 32'h0);
      IRQ_ACK <= 3'h2;
      @(posedge REF_CLK);
      IRQ_ACK <= 3'h0;
      @(negedge REF_CLK);
      chk("ack clears", IRQ[FL_MA], 1'b0);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_FLAG, 32'h7);
      rd(OFS_COUNT, c0);
      ea = 1'b0;
      for (int k = 0; k < 10; k++)
      begin
         c = (k < 4) ? k[1:0] : 2'($urandom % 4);
         wr(OFS_CTRL_A, {24'h0, c, c, 4'h0});
         wr(OFS_CTRL_B, 32'hc0);
         ea = frc_out(ea, c);
         cyc(2);
         chk("force out a", COMPARE_OUT_A, ea);
         chk("force out b", COMPARE_OUT_B, ea);
      end
      rd(OFS_FLAG, q);
      chk("force no flag", q, 32'h0);
      rd(OFS_COUNT, q);
      chk("force no count", q, c0);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_CMP_A, 32'h33);
      wr(OFS_COUNT, 32'h33);
      wr(OFS_CTRL_B, CS_DIRECT);
      wr(OFS_CTRL_B, 32'h0);
      rd(OFS_FLAG, q);
      chk("write blocks match", q[FL_MA], 1'b0);
      wr(OFS_CTRL_A, {30'h0, WM_FAST});
      wr(OFS_CMP_A, 32'h20);
      rd(OFS_CMP_A, q);
      chk("buffer read", q, 32'h20);
      wr(OFS_COUNT, 32'h10);
      wr(OFS_FLAG, 32'h7);
      wr(OFS_CTRL_B, CS_DIRECT);
      wait_irq(FL_MA, 20, hit);
      chk("buffered compare", hit, 1'b0);
      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_CMP_A, 32'h08);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_MASK, 32'h1);
      wr(OFS_FLAG, 32'h7);
      wr(OFS_CTRL_A, 32'h81);
      wr(OFS_CTRL_B, 32'h09);
      wait_irq(FL_OVF, 40, hit);
      chk("phase overflow", hit, 1);
      repeat (4)
      begin
         rd(OFS_COUNT, q);
         chk("phase top", q <= 32'h08, 1);
      end
      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_COUNT, 32'h0);
      n = 1 + $urandom % 9;
      wr(OFS_CTRL_B, CS_EXT_RISE);
      repeat (n) pulse();
      wr(OFS_CTRL_B, CS_EXT_FALL);
      repeat (n) pulse();
      wr(OFS_CTRL_B, 32'h0);
      rd(OFS_COUNT, q);
      chk("pin edges", q, 2 * n);
      end_of_test();
   end
endmodule : tb
